// ===== dv/onw_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches the link where both design ends meet
module onw_link_checker #(
  parameter int unsigned PER_BIT_BURN_NS = 100000
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // link signals
  input wire logic        cmdValid,
  input wire logic [15:0] cmdFrame,
  input wire logic [1:0]  cmdFmt,
  input wire logic        respValid,
  input wire logic [15:0] respFrame
);
  localparam int BC   = PER_BIT_BURN_NS / 20;
  localparam int LMAX = 2 + 4 * BC;
  logic [7:0]  since_r;
  logic [15:0] lastCmd_r;
  logic [1:0]  lastFmt_r;
  // cycles since the last command; saturates so long idle never wraps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) since_r <= 8'hff;
    else if (cmdValid) since_r <= 8'h01;
    else if (since_r != 8'hff) since_r <= since_r + 8'h01;
  end
  // last command, so each answer can be tied to its cause
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) {lastCmd_r, lastFmt_r} <= 18'h0;
    else if (cmdValid) {lastCmd_r, lastFmt_r} <= {cmdFrame, cmdFmt};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  resp_pulse_a: assert property (respValid |=> !respValid)
    else $error("answer strobe longer than one cycle");
  resp_hold_a: assert property (!respValid |-> $stable(respFrame))
    else $error("answer frame moved between answers");
  resp_ones_a: assert property (respValid |-> respFrame[7:6] == 2'h3)
    else $error("answer bits 7 and 6 not set");
  resp_delay_a: assert property (respValid |-> since_r >= 2 && since_r <= LMAX
    && (since_r - 2) % BC == 0) else $error("answer delay off the burn grid");
  cmd_spacing_a: assert property (cmdValid |-> since_r > LMAX)
    else $error("command sent inside the burn time");
  resp_code_a: assert property (respValid |-> lastCmd_r[3:0] == 4'h9 && !lastFmt_r[1])
    else $error("answer to a foreign code or short format");
  resp_global_a: assert property (respValid |-> lastCmd_r[7:4] != 4'h0)
    else $error("answer to the global address");
  resp_loc_a: assert property (respValid && respFrame[7:4] != 4'hf
    |-> respFrame[11:8] == lastCmd_r[15:12]) else $error("answer location differs");
  resp_self_a: assert property (respValid && respFrame[11:4] == 8'h0f
    |-> respFrame[3:0] == respFrame[15:12]) else $error("address not echoed in data");
  resp_addr_a: assert property (respValid && lastCmd_r[15:12] != 4'h7
    |-> respFrame[15:12] == lastCmd_r[7:4]) else $error("answer from another address");
endmodule : onw_link_checker
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) check(nm, 16'(ex), 16'(gt))
// host and satellite joined on one link; a second satellite is driven by the bench
module testbench;
  localparam int BC  = 5;
  localparam int GAP = 4 * BC + 6;
  logic        ref_clk = 1'b0;
  logic        rst_b, ce, permit, enh, reqValid, reqEnh, reqReady, ansValid;
  logic        lockA, lockB, edcA, edcB, strb, busyA, busyB;
  logic [1:0]  bank;
  logic [3:0]  edcRef, reqLoc, reqData, reqAddr, addrA, addrB, bDat;
  logic [5:0]  bIdx, expIdx;
  logic [15:0] ansFrame;
  logic [23:0] eA, eB;
  logic [3:0]  mir [2][64];
  logic [23:0] qA[$], qB[$];
  int          cyc, t0, seed, k, strobes, expStrobes, failCount, totalChecks;
  onw_link_if lnkA ();
  onw_link_if lnkB ();
  onw_host_end #(.PER_BIT_BURN_NS(100)) u_onw_host_end (.ref_clk, .rst_b, .ce,
    .link(lnkA.host), .reqValid, .reqLoc, .reqData, .reqAddr, .reqEnh, .reqReady,
    .ansValid, .ansFrame);
  onw_dev_end #(.PER_BIT_BURN_NS(100)) u_onw_dev_end (.ref_clk, .rst_b, .ce,
    .link(lnkA.dev), .otpBurnPermit(permit), .otpBank(bank), .enhLongEn(enh), .edcRef,
    .otpBurnStrobe(), .otpBurnIdx(), .otpBurnData(), .busAddr(addrA), .lockUser(lockA),
    .edcMismatch(edcA), .busy(busyA));
  onw_dev_end #(.PER_BIT_BURN_NS(100)) u_onw_dev_end_b (.ref_clk, .rst_b, .ce,
    .link(lnkB.dev), .otpBurnPermit(permit), .otpBank(bank), .enhLongEn(enh), .edcRef,
    .otpBurnStrobe(strb), .otpBurnIdx(bIdx), .otpBurnData(bDat), .busAddr(addrB),
    .lockUser(lockB), .edcMismatch(edcB), .busy(busyB));
  onw_link_checker #(.PER_BIT_BURN_NS(100)) u_onw_link_checker (.ref_clk, .rst_b,
    .cmdValid(lnkA.cmdValid), .cmdFrame(lnkA.cmdFrame), .cmdFmt(lnkA.cmdFmt),
    .respValid(lnkA.respValid), .respFrame(lnkA.respFrame));
  // clock, and a cycle count for answer delays
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  task automatic check(input string nm, input logic [15:0] ex, gt);
    totalChecks++;
    if (gt !== ex) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, ex, gt);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // writable bits per {bank, location}; zero marks an unused place
  function automatic logic [3:0] mk(input logic [5:0] i);
    case (i)
      6'h07, 6'h0a: mk = 4'h8;
      6'h08: mk = 4'hc;
      6'h16: mk = 4'h3;
      6'h27: mk = 4'h2;
      default: mk = (i >= 6'h17 && i <= 6'h1e || i >= 6'h28 && i <= 6'h2f) ? 4'hf : 4'h0;
    endcase
  endfunction : mk
  function automatic logic [3:0] xr(input int d);
    xr = 4'h0;
    for (int i = 0; i < 64; i++) xr ^= mir[d][i];
  endfunction : xr
  // notes the answer one end owes, and moves the bench mirror along
  task automatic predict(input int d, input logic [1:0] f, input logic [15:0] fr, input bit drop);
    logic [5:0]  ix;
    logic [3:0]  m, a;
    logic [23:0] e;
    int          n, lat;
    ix = {bank, fr[15:12]};
    m = mk(ix);
    if (drop || f[1] || (f[0] && !enh) || fr[3:0] !== 4'h9 || fr[7:4] == 4'h0
        || fr[7:4] !== mir[d][6'h17]) return;
    mir[d][ix] = (mir[d][ix] & ~m) | (fr[11:8] & m);
    a = mir[d][6'h17];
    n = $countones(fr[11:8] & m);
    lat = (!permit || m == 4'h0) ? 2 : 2 + BC * (n == 0 ? 1 : n);
    e = permit ? {8'(lat), a, fr[15:12], 2'h3, bank, (m == 4'h0) ? a : mir[d][ix]}
               : {8'(lat), a, 4'h0, 4'hf, a};
    if (d == 0) qA.push_back(e);
    else qB.push_back(e);
    if (d == 1 && permit && m != 4'h0) begin
      expStrobes++;
      expIdx = ix;
    end
  endtask : predict
  task automatic stat(input int d, input logic [3:0] ba, input logic lk, mm);
    `CHK("pending notes", 0, d ? qB.size() : qA.size());
    `CHK("bus address", mir[d][6'h17], ba);
    `CHK("lock flag", mir[d][6'h07][3], lk);
    `CHK("mismatch", mir[d][6'h07][3] & (xr(d) != edcRef), mm);
    `CHK("idle", 0, d ? busyB : busyA);
  endtask : stat
  task automatic tx(input logic [1:0] f, input logic [15:0] fr, input bit drop, input int gap);
    lnkB.cmdValid = 1'b1;
    lnkB.cmdFmt = f;
    lnkB.cmdFrame = fr;
    if (!drop) t0 = cyc;
    predict(1, f, fr, drop);
    @(negedge ref_clk);
    // one edge after the take: busy exactly when the frame was owed an answer
    if (!drop) `CHK("busy after take", qB.size() != 0, busyB);
    lnkB.cmdValid = 1'b0;
    lnkB.cmdFrame = ~fr; // a stale frame must never be reused
    repeat (gap) @(negedge ref_clk);
    if (gap > 2) stat(1, addrB, lockB, edcB);
  endtask : tx
  task automatic hreq(input logic [3:0] l, dt, input logic e);
    int j;
    for (j = 0; j < 100 && reqReady !== 1'b1; j++) @(negedge ref_clk);
    if (j == 100) begin
      `CHK("host ready wait", 0, 1);
      summarize();
    end
    reqValid = 1'b1;
    reqLoc = l;
    reqData = dt;
    reqAddr = mir[0][6'h17];
    reqEnh = e;
    predict(0, {1'b0, e}, {l, dt, mir[0][6'h17], 4'h9}, 1'b0);
    @(negedge ref_clk);
    reqValid = 1'b0;
    for (j = 0; j < 100 && qA.size() != 0; j++) @(negedge ref_clk);
    if (j == 100) begin
      `CHK("host answer wait", 0, 1);
      summarize();
    end
  endtask : hreq
  // each answer takes the oldest note of its end
  always @(negedge ref_clk) begin
    if (lnkB.respValid === 1'b1) begin
      `CHK("noted answer", 1, qB.size() != 0);
      eB = qB.size() ? qB.pop_front() : 24'h0;
      `CHK("response frame", eB[15:0], lnkB.respFrame);
      `CHK("response delay", eB[23:16], cyc - t0);
    end
    if (ansValid === 1'b1) begin
      eA = qA.size() ? qA.pop_front() : 24'h0;
      `CHK("host answer", eA[15:0], ansFrame);
    end
    if (strb === 1'b1) begin
      strobes++;
      `CHK("burn index", expIdx, bIdx);
      `CHK("burn data", mir[1][expIdx], bDat);
    end
  end
  initial begin
    {rst_b, permit, enh, reqValid, reqEnh, bank, reqLoc, reqData, reqAddr} = '0;
    {cyc, strobes, expStrobes, failCount, totalChecks} = '0;
    ce = 1'b1;
    seed = 22;
    edcRef = 4'h5;
    {lnkB.cmdValid, lnkB.cmdFmt, lnkB.cmdFrame} = '0;
    for (k = 0; k < 128; k++) mir[k / 64][k % 64] = (k % 64 == 23) ? onw_pkg::ADDR_RESET : 4'h0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    // host path: mirror-only writes, then burns, one in enhanced format
    enh = 1'b1;
    bank = 2'h1;
    for (k = 0; k < 6; k++) begin
      permit = k > 2;
      hreq({1'b1, 3'($random(seed))}, 4'($random(seed)), k == 5);
    end
    stat(0, addrA, lockA, edcA);
    // frames that must be dropped silently, then one enhanced long frame once enhLongEn is set
    enh = 1'b0;
    permit = 1'b0;
    tx(2'h2, 16'h8519, 0, 8);
    tx(2'h3, 16'h8519, 0, 8);
    tx(2'h1, 16'h8519, 0, 8);
    tx(2'h0, 16'h8518, 0, 8);
    tx(2'h0, 16'h8504, 0, 8);
    tx(2'h0, 16'h8509, 0, 8);
    tx(2'h0, 16'h8529, 0, 8);
    enh = 1'b1;
    tx(2'h1, 16'h8519, 0, GAP);
    // new address burned in and answered from it, then a frame while a burn runs, then the lock
    permit = 1'b1;
    tx(2'h0, {4'h7, 4'h6, mir[1][6'h17], 4'h9}, 0, GAP);
    tx(2'h0, 16'h8f69, 0, 1);
    tx(2'h0, 16'h9f69, 1, GAP);
    bank = 2'h0;
    tx(2'h0, 16'h7869, 0, GAP);
    edcRef = xr(1);
    @(negedge ref_clk);
    stat(1, addrB, lockB, edcB);
    // random writes under the lock, mirror only and then burning
    for (k = 0; k < 30; k++) begin
      permit = k >= 12;
      bank = 2'($random(seed));
      edcRef = 4'($random(seed));
      tx(2'h0, {1'b1, 3'($random(seed)), 4'($random(seed)), mir[1][6'h17], 4'h9}, 0, GAP);
    end
    // a low clock enable mid-burn must hold the timer, so the answer comes later
    bank = 2'h1;
    tx(2'h0, {4'h9, 4'hf, mir[1][6'h17], 4'h9}, 0, 1);
    ce = 1'b0;
    repeat (4) @(negedge ref_clk);
    ce = 1'b1;
    t0 = t0 + 4;
    repeat (GAP) @(negedge ref_clk);
    stat(1, addrB, lockB, edcB);
    `CHK("burn count", expStrobes, strobes);
    summarize();
  end
endmodule : testbench
`default_nettype wire

// ===== include/onw_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// frame-level link between bus master and satellite
interface onw_link_if;
  logic        cmdValid;
  logic [15:0] cmdFrame;
  logic [1:0]  cmdFmt;
  logic        respValid;
  logic [15:0] respFrame;

  modport dev (input cmdValid, input cmdFrame, input cmdFmt, output respValid, output respFrame);
  modport host (output cmdValid, output cmdFrame, output cmdFmt, input respValid, input respFrame);
endinterface : onw_link_if
`default_nettype wire

// ===== include/onw_pkg.sv
// shared constants for the one-time-programmable nibble write command
package onw_pkg;

  // frame geometry: {location, data, bus address, command code}
  localparam int unsigned NIB         = 4;
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned FLD_CMD_LSB = 0;
  localparam int unsigned FLD_ADR_LSB = 4;
  localparam int unsigned FLD_DAT_LSB = 8;
  localparam int unsigned FLD_LOC_LSB = 12;

  // response fields, low bit positions
  localparam int unsigned RSP_NIB_LSB  = 0;
  localparam int unsigned RSP_BNK_LSB  = 4;
  localparam int unsigned RSP_ONES_LSB = 6;
  localparam int unsigned RSP_LOC_LSB  = 8;
  localparam int unsigned RSP_ADR_LSB  = 12;

  localparam logic [3:0] CMD_NIBBLE_BURN = 4'h9;
  localparam logic [3:0] GLOBAL_ADDR     = 4'h0;
  localparam logic [1:0] ONES2           = 2'h3;
  localparam logic [3:0] ONES4           = 4'hf;
  localparam logic [3:0] ZERO4           = 4'h0;

  // command formats seen on the link
  typedef enum logic [1:0] {
    FMT_STD_LONG  = 2'b00,
    FMT_ENH_LONG  = 2'b01,
    FMT_STD_SHORT = 2'b10,
    FMT_ENH_SHORT = 2'b11
  } onw_fmt_e;

  // mirror array: index is {bank, location}
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned DEPTH      = 64;
  localparam logic [5:0]  ADDR_IDX   = 6'h17;
  localparam logic [5:0]  LOCK_IDX   = 6'h07;
  localparam int unsigned LOCK_BIT   = 3;
  localparam logic [3:0]  ADDR_RESET = 4'h1;

  // timing
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned MAX_BURN_BITS = 4;
  localparam int unsigned CNT_W         = 20;

  // writable bits of each nibble location; zero marks an unused location
  function automatic logic [3:0] nibble_mask(input logic [5:0] idx);
    logic [3:0] m;
    m = 4'h0;
    unique case (idx[5:4])
      2'h0: begin
        if (idx[3:0] == 4'h7) m = 4'h8;
        if (idx[3:0] == 4'h8) m = 4'hc;
        if (idx[3:0] == 4'ha) m = 4'h8;
      end
      2'h1: begin
        if (idx[3:0] == 4'h6) m = 4'h3;
        if (idx[3:0] >= 4'h7 && idx[3:0] <= 4'he) m = 4'hf;
      end
      2'h2: begin
        if (idx[3:0] == 4'h7) m = 4'h2;
        if (idx[3:0] >= 4'h8) m = 4'hf;
      end
      2'h3: m = 4'h0;
    endcase
    return m;
  endfunction : nibble_mask

endpackage : onw_pkg

// ===== rtl/onw_dev_end.sv
`timescale 1ns/100ps
`default_nettype none

module onw_dev_end #(
  parameter int unsigned PER_BIT_BURN_NS = 100000
) (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // link to bus master
  onw_link_if.dev         link,
  // settings from initialization and format control
  input  wire logic       otpBurnPermit,
  input  wire logic [1:0] otpBank,
  input  wire logic       enhLongEn,
  input  wire logic [3:0] edcRef,
  // OTP array programming port
  output logic            otpBurnStrobe,
  output logic [5:0]      otpBurnIdx,
  output logic [3:0]      otpBurnData,
  // device status
  output logic [3:0]      busAddr,
  output logic            lockUser,
  output logic            edcMismatch,
  output logic            busy
);

  // per-bit burn time in cycles, rounded up, never below one
  localparam int unsigned BURN_RAW = (PER_BIT_BURN_NS * onw_pkg::CLK_MHZ + 999) / 1000;
  localparam int unsigned BURN_CYC = (BURN_RAW < 1) ? 1 : BURN_RAW;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURN = 2'b01,
    ST_RESP = 2'b10
  } onw_state_e;

  onw_state_e               state_r;
  onw_state_e               state_nxt;
  logic [3:0]               mirror_r [onw_pkg::DEPTH];
  logic [5:0]               idx_r;
  logic                     permit_r;
  logic                     used_r;
  logic [onw_pkg::CNT_W-1:0] cnt_r;
  logic                     respValid_r;
  logic [15:0]              respFrame_r;
  logic                     strobe_r;
  logic [5:0]               burnIdx_r;
  logic [3:0]               burnData_r;

  // frame fields
  wire logic [3:0] fCmd = link.cmdFrame[onw_pkg::FLD_CMD_LSB +: onw_pkg::NIB];
  wire logic [3:0] fAdr = link.cmdFrame[onw_pkg::FLD_ADR_LSB +: onw_pkg::NIB];
  wire logic [3:0] fDat = link.cmdFrame[onw_pkg::FLD_DAT_LSB +: onw_pkg::NIB];
  wire logic [3:0] fLoc = link.cmdFrame[onw_pkg::FLD_LOC_LSB +: onw_pkg::NIB];

  // acceptance decode
  wire logic fmtOk   = (link.cmdFmt == onw_pkg::FMT_STD_LONG) ||
                       ((link.cmdFmt == onw_pkg::FMT_ENH_LONG) && enhLongEn);
  wire logic codeOk  = (fCmd == onw_pkg::CMD_NIBBLE_BURN);
  wire logic adrOk   = (fAdr != onw_pkg::GLOBAL_ADDR) && (fAdr == busAddr);
  wire logic accept  = link.cmdValid && (state_r == ST_IDLE) && fmtOk && codeOk && adrOk;

  // target nibble and the value the mirror takes
  wire logic [5:0] idx     = {otpBank, fLoc};
  wire logic [3:0] mask    = onw_pkg::nibble_mask(idx);
  wire logic       used    = |mask;
  wire logic [3:0] newNib  = (mirror_r[idx] & ~mask) | (fDat & mask);
  wire logic       mirWr   = accept && used;
  // only a set permit flag burns; supply level is deliberately not consulted
  wire logic       burnGo  = mirWr && otpBurnPermit;

  // bits actually being burned, counted as ones in the written nibble
  function automatic logic [2:0] bit_count(input logic [3:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < onw_pkg::NIB; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction : bit_count

  wire logic [2:0] nBitsRaw = bit_count(fDat & mask);
  wire logic [2:0] nBits    = (nBitsRaw == 3'h0) ? 3'h1 : nBitsRaw;
  wire logic [onw_pkg::CNT_W-1:0] burnLen =
    onw_pkg::CNT_W'(BURN_CYC) * onw_pkg::CNT_W'(nBits);

  // mirror storage; the address location resets to its default address
  genvar g;
  generate
    for (g = 0; g < onw_pkg::DEPTH; g++) begin : gMir
      localparam logic [3:0] RST = (g == onw_pkg::ADDR_IDX) ? onw_pkg::ADDR_RESET : 4'h0;
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          mirror_r[g] <= RST;
        end else if (ce && mirWr && (idx == onw_pkg::IDX_W'(g))) begin
          mirror_r[g] <= newNib;
        end
      end
    end
  endgenerate

  assign busAddr  = mirror_r[onw_pkg::ADDR_IDX];
  assign lockUser = mirror_r[onw_pkg::LOCK_IDX][onw_pkg::LOCK_BIT];

  // error detection: xor fold of the whole mirror, recomputed on every write
  logic [3:0] edcCalc;
  always_comb begin
    edcCalc = 4'h0;
    for (int i = 0; i < onw_pkg::DEPTH; i++) begin
      edcCalc = edcCalc ^ mirror_r[i];
    end
  end
  assign edcMismatch = lockUser && (edcCalc != edcRef);

  // sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = burnGo ? ST_BURN : ST_RESP;
        end
      end
      ST_BURN: begin
        if (cnt_r <= onw_pkg::CNT_W'(1)) begin
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // captured command context
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_r    <= 6'h00;
      permit_r <= 1'b0;
      used_r   <= 1'b0;
    end else if (ce && accept) begin
      idx_r    <= idx;
      permit_r <= otpBurnPermit;
      used_r   <= used;
    end
  end

  // burn timer loaded with per-bit time times bit count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (burnGo) begin
        cnt_r <= burnLen;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - onw_pkg::CNT_W'(1);
      end
    end
  end

  // programming strobe to the OTP array, one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_r   <= 1'b0;
      burnIdx_r  <= 6'h00;
      burnData_r <= 4'h0;
    end else if (ce) begin
      strobe_r <= burnGo;
      if (burnGo) begin
        burnIdx_r  <= idx;
        burnData_r <= newNib;
      end
    end
  end

  // response assembled after the write, so the mirror and address are current
  wire logic [3:0] rdBack  = used_r ? mirror_r[idx_r] : busAddr;
  wire logic [15:0] rspOn  = {busAddr, idx_r[3:0], onw_pkg::ONES2, idx_r[5:4], rdBack};
  wire logic [15:0] rspOff = {busAddr, onw_pkg::ZERO4, onw_pkg::ONES4, busAddr};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      respValid_r <= 1'b0;
      respFrame_r <= 16'h0000;
    end else if (ce) begin
      respValid_r <= (state_r == ST_RESP);
      if (state_r == ST_RESP) begin
        respFrame_r <= permit_r ? rspOn : rspOff;
      end
    end
  end

  assign link.respValid = respValid_r;
  assign link.respFrame = respFrame_r;
  assign otpBurnStrobe  = strobe_r;
  assign otpBurnIdx     = burnIdx_r;
  assign otpBurnData    = burnData_r;
  assign busy           = (state_r != ST_IDLE) || respValid_r;

endmodule : onw_dev_end
`default_nettype wire

// ===== rtl/onw_host_end.sv
`timescale 1ns/100ps
`default_nettype none
// bus master end: sends one nibble write, then holds off for the full burn time
module onw_host_end #(
  parameter int unsigned PER_BIT_BURN_NS = 100000
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // link to satellite
  onw_link_if.host         link,
  // user request
  input  wire logic        reqValid,
  input  wire logic [3:0]  reqLoc,
  input  wire logic [3:0]  reqData,
  input  wire logic [3:0]  reqAddr,
  input  wire logic        reqEnh,
  output logic             reqReady,
  // user answer
  output logic             ansValid,
  output logic [15:0]      ansFrame
);

  // worst case spacing: four bits plus four cycles for the device's turnaround
  localparam int unsigned BURN_RAW = (PER_BIT_BURN_NS * onw_pkg::CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC  = BURN_RAW * onw_pkg::MAX_BURN_BITS + 4;

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } onw_hstate_e;

  onw_hstate_e               state_r;
  logic [onw_pkg::CNT_W-1:0] gap_r;
  logic                      cmdValid_r;
  logic [15:0]               cmdFrame_r;
  logic [1:0]                cmdFmt_r;
  logic                      ansValid_r;
  logic [15:0]               ansFrame_r;

  wire logic send = reqValid && (state_r == HS_IDLE);

  // issue the command and start the spacing counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= HS_IDLE;
      gap_r      <= '0;
      cmdValid_r <= 1'b0;
      cmdFrame_r <= 16'h0000;
      cmdFmt_r   <= 2'h0;
    end else if (ce) begin
      cmdValid_r <= send;
      if (send) begin
        cmdFrame_r <= {reqLoc, reqData, reqAddr, onw_pkg::CMD_NIBBLE_BURN};
        cmdFmt_r   <= reqEnh ? onw_pkg::FMT_ENH_LONG : onw_pkg::FMT_STD_LONG;
        gap_r      <= onw_pkg::CNT_W'(GAP_CYC);
        state_r    <= HS_WAIT;
      end else if (state_r == HS_WAIT) begin
        gap_r <= gap_r - onw_pkg::CNT_W'(1);
        if (gap_r <= onw_pkg::CNT_W'(1)) begin
          state_r <= HS_IDLE;
        end
      end
    end
  end

  // capture the answer so the user can read back and compare
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ansValid_r <= 1'b0;
      ansFrame_r <= 16'h0000;
    end else if (ce) begin
      ansValid_r <= link.respValid;
      if (link.respValid) begin
        ansFrame_r <= link.respFrame;
      end
    end
  end

  assign link.cmdValid = cmdValid_r;
  assign link.cmdFrame = cmdFrame_r;
  assign link.cmdFmt   = cmdFmt_r;
  assign reqReady      = (state_r == HS_IDLE);
  assign ansValid      = ansValid_r;
  assign ansFrame      = ansFrame_r;

endmodule : onw_host_end
`default_nettype wire
